// ---- bench/bpsd_lamp_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
module bpsd_lamp_bank (
  // clock and lamp drive
  input  wire logic                     clock_i,
  input  wire logic                     error_flag_lamp_i,
  input  wire logic                     loader_phase_lamp_i,
  input  wire logic                     exec_source_lamp_i,
  input  wire logic [4:0]               code_lamps_i,
  // what service staff read off the bank
  output var  bpsd_pkg::bpsd_lamps_type view_o,
  output var  logic                     unused_seen_o
);
  // lamps have no memory of their own: the picture is the drive itself
  always_comb begin
    view_o = {error_flag_lamp_i, loader_phase_lamp_i, exec_source_lamp_i, code_lamps_i};
  end

  // a viewer notes status 01h shown with the error lamp dark, which a healthy board never shows
  logic seen_q = 1'b0;
  always @(posedge clock_i) begin
    if (code_lamps_i === 5'h01 && error_flag_lamp_i === 1'b0) begin
      seen_q <= 1'b1;
    end
  end
  assign unused_seen_o = seen_q;
endmodule
`default_nettype wire

// ---- bench/test_boot_progress_status_display.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_boot_progress_status_display;
  logic                       clock;
  logic                       reset_n;
  bpsd_pkg::bpsd_apb_req_type req;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [4:0]                 code_lamps;
  logic                       err_lamp;
  logic                       ldr_lamp;
  logic                       exe_lamp;
  logic                       unused_seen;
  logic                       step_go;
  logic [4:0]                 step_code;
  int                         go_pulses = 0;
  bpsd_pkg::bpsd_lamps_type   view;
  logic [31:0]                rdat;
  logic                       rerr;
  int                         failures;
  int                         compares;
  logic [4:0]                 walk [21] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
    5'h09, 5'h0A, 5'h0D, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17, 5'h18,
    5'h1E, 5'h1F};

  bpsd_top dut (
    .CLOCK_I(clock), .RESET_N_I(reset_n), .PSEL_I(req.sel), .PENABLE_I(req.enable),
    .PWRITE_I(req.write), .PADDR_I(req.addr), .PWDATA_I(req.wdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .STEP_GO_O(step_go), .STEP_CODE_O(step_code),
    .ERROR_FLAG_LAMP_O(err_lamp), .LOADER_PHASE_LAMP_O(ldr_lamp),
    .EXEC_SOURCE_LAMP_O(exe_lamp), .CODE_LAMPS_O(code_lamps)
  );

  bpsd_lamp_bank bank (
    .clock_i(clock), .error_flag_lamp_i(err_lamp), .loader_phase_lamp_i(ldr_lamp),
    .exec_source_lamp_i(exe_lamp), .code_lamps_i(code_lamps), .view_o(view),
    .unused_seen_o(unused_seen)
  );

  initial clock = 1'b0;
  always #20 clock = ~clock;

  // every entered code should raise exactly one step request
  always @(posedge clock) begin
    if (step_go === 1'b1) begin
      go_pulses++;
    end
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (failures == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // setup, then hold the access phase until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    int n = 0;
    @(posedge clock);
    req <= '{sel: 1'b1, enable: 1'b0, write: wr, addr: addr, wdata: wd};
    @(posedge clock);
    req.enable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) failures++;
    rdat = prdata;
    rerr = pslverr;
    req <= '0;
  endtask

  // poll status until the sequencer has left the enter state
  task automatic settle();
    int n = 0;
    do begin
      apb(1'b0, bpsd_pkg::STATUS_OFS, 32'h0000_0000);
      n++;
    end while (rdat[7:6] === 2'd0 && n < 20);
    if (rdat[7:6] === 2'd0) failures++;
  endtask

  task automatic look(input logic [1:0] st, input logic [4:0] code);
    logic e;
    logic l;
    e = (st == 2'd2);
    l = (code == 5'h1F) && !e;
    check({24'h0, rdat[7:0]}, {24'h0, st, e, code});
    check({27'h0, step_code}, {27'h0, code});
    if (st != 2'd3) check({24'h0, view}, {24'h0, e, l, !l, code});
  endtask

  task automatic step(input logic [31:0] res, input logic [4:0] code, input logic [1:0] st);
    apb(1'b1, bpsd_pkg::RESULT_OFS, res);
    settle();
    look(st, code);
  endtask

  task automatic restart();
    apb(1'b1, bpsd_pkg::CTRL_OFS, 32'h0000_0008);
    settle();
    look(2'd1, 5'h00);
  endtask

  task automatic to_tape();
    restart();
    for (int i = 0; i < 9; i++) step(32'h0000_0001, walk[i], 2'd1);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    compares = 0;
    reset_n  = 1'b0;
    req      = '0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    settle();
    look(2'd1, 5'h00);
    foreach (walk[i]) step(32'h0000_0001, walk[i], 2'd1);
    step(32'h0000_0001, 5'h1F, 2'd3);
    check({31'h0, unused_seen}, 32'h0000_0000);
    check(go_pulses, 32'h0000_0016);
    to_tape();
    step(32'h0000_0000, 5'h0B, 2'd1);
    step(32'h0000_0000, 5'h0C, 2'd1);
    step(32'h0000_0000, 5'h0C, 2'd1);
    step(32'h0000_0001, 5'h0E, 2'd1);
    step(32'h0000_0000, 5'h10, 2'd1);
    step(32'h0000_0000, 5'h10, 2'd2);
    repeat (40) @(posedge clock);
    step(32'h0000_0001, 5'h10, 2'd2);
    to_tape();
    step(32'h0000_0000, 5'h0B, 2'd1);
    step(32'h0000_0001, 5'h0E, 2'd1);
    step(32'h0000_0001, 5'h0F, 2'd1);
    step(32'h0000_0001, 5'h10, 2'd1);
    restart();
    step(32'h0000_0001, 5'h02, 2'd1);
    step(32'h0000_0000, bpsd_pkg::E_PAGE_ADDR, 2'd2);
    restart();
    for (int i = 0; i < 5; i++) step(32'h0000_0001, walk[i], 2'd1);
    step(32'h0000_0700, 5'h07, 2'd2);
    // run mode takes over only the source and loader lamps
    apb(1'b1, bpsd_pkg::CTRL_OFS, 32'h0000_0003);
    apb(1'b0, bpsd_pkg::CTRL_OFS, 32'h0000_0000);
    check(rdat, 32'h0000_0003);
    check({24'h0, view}, 32'h0000_00A7);
    apb(1'b1, bpsd_pkg::CTRL_OFS, 32'h0000_0005);
    apb(1'b0, bpsd_pkg::LAMPS_OFS, 32'h0000_0000);
    check(rdat, 32'h0000_00C7);
    check({24'h0, view}, 32'h0000_00C7);
    apb(1'b0, 8'h10, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001);
    check(rdat, 32'h0000_0000);
    apb(1'b1, bpsd_pkg::CTRL_OFS, 32'h0000_0000);
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    settle();
    look(2'd1, 5'h00);
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- rtl/bpsd_lamp_hold.sv ----
`timescale 1ns/10ps
`default_nettype none
module bpsd_lamp_hold (
  // clock and reset
  input  wire logic                    clock_i,
  input  wire logic                    reset_n_i,
  // new picture
  input  wire logic                    load_i,
  input  wire bpsd_pkg::bpsd_lamps_type lamps_i,
  // lamp drive
  output var  bpsd_pkg::bpsd_lamps_type lamps_o
);

  bpsd_pkg::bpsd_lamps_type s_q;
  bpsd_pkg::bpsd_lamps_type s_d;

  // picture only moves on a load, so a hang leaves the last step lit
  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d = lamps_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s_q <= bpsd_pkg::LAMPS_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign lamps_o = s_q;

endmodule
`default_nettype wire

// ---- rtl/bpsd_pkg.sv ----
package bpsd_pkg;

  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS         = 8'h00;
  localparam logic [7:0] RESULT_OFS       = 8'h04;
  localparam logic [7:0] STATUS_OFS       = 8'h08;
  localparam logic [7:0] LAMPS_OFS        = 8'h0C;
  localparam int         CTRL_RUN_BIT     = 0;
  localparam int         CTRL_USER_BIT    = 1;
  localparam int         CTRL_IDLE_BIT    = 2;
  localparam int         CTRL_RESTART_BIT = 3;
  localparam int         RES_OK_BIT       = 0;
  localparam int         RES_ERR_LSB      = 8;
  localparam int         STAT_ERR_BIT     = 5;
  localparam int         STAT_STATE_LSB   = 6;
  localparam int         STAT_PEND_BIT    = 8;
  localparam logic [2:0] CTRL_RESET       = 3'h0;
  localparam logic [7:0] LAMPS_RESET      = 8'h00;

  // ----------------------------------------------------------------
  // status codes
  // ----------------------------------------------------------------
  localparam logic [4:0] C_RESET       = 5'h00;
  localparam logic [4:0] C_UNUSED      = 5'h01;
  localparam logic [4:0] C_PAGE_ADDR   = 5'h02;
  localparam logic [4:0] C_PAGE_INV    = 5'h03;
  localparam logic [4:0] C_PAGE_ZERO   = 5'h04;
  localparam logic [4:0] C_PAGE_ONE    = 5'h05;
  localparam logic [4:0] C_TAPE_INIT   = 5'h0A;
  localparam logic [4:0] C_NVM_RELOAD  = 5'h0B;
  localparam logic [4:0] C_RECAL       = 5'h0C;
  localparam logic [4:0] C_TAPE_DUMP   = 5'h0D;
  localparam logic [4:0] C_DUMP_SRCH   = 5'h0E;
  localparam logic [4:0] C_DISK_DUMP   = 5'h0F;
  localparam logic [4:0] C_BASE_ADDR   = 5'h10;
  localparam logic [4:0] C_BASE_LAST   = 5'h13;
  localparam logic [4:0] C_EXP_LAST    = 5'h17;
  localparam logic [4:0] C_LOADER_SRCH = 5'h18;
  localparam logic [4:0] C_NVM_RELOAD2 = 5'h19;
  localparam logic [4:0] C_RECAL2      = 5'h1A;
  localparam logic [4:0] C_DISK_SRCH   = 5'h1C;
  localparam logic [4:0] C_LOAD_LDR    = 5'h1E;
  localparam logic [4:0] C_EXEC_LDR    = 5'h1F;

  // ----------------------------------------------------------------
  // error codes for page memory failures
  // ----------------------------------------------------------------
  localparam logic [4:0] E_PAGE_ADDR   = 5'h14;
  localparam logic [4:0] E_PAGE_INV    = 5'h15;
  localparam logic [4:0] E_PAGE_ZERO   = 5'h17;
  localparam logic [4:0] E_PAGE_ONE    = 5'h18;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_ENTER, ST_WAIT, ST_HALT, ST_DONE} bpsd_state_type;

  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } bpsd_apb_req_type;

  typedef struct packed {
    logic       err;
    logic       loader;
    logic       exec;
    logic [4:0] code;
  } bpsd_lamps_type;

endpackage

// ---- rtl/bpsd_top.sv ----
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module bpsd_top (
  // clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RESET_N_I,
  // apb slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // step request to firmware
  output logic             STEP_GO_O,
  output logic      [4:0]  STEP_CODE_O,
  // status lamps
  output logic             ERROR_FLAG_LAMP_O,
  output logic             LOADER_PHASE_LAMP_O,
  output logic             EXEC_SOURCE_LAMP_O,
  output logic      [4:0]  CODE_LAMPS_O
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    bpsd_pkg::bpsd_state_type state;
    logic [4:0]               code;
    logic                     err;
    logic                     go;
    logic [2:0]               ctrl;
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } bpsd_regs_type;

  localparam bpsd_regs_type S_INIT = '{
    state:   bpsd_pkg::ST_ENTER,
    code:    bpsd_pkg::C_RESET,
    err:     1'b0,
    go:      1'b0,
    ctrl:    bpsd_pkg::CTRL_RESET,
    pready:  1'b0,
    pslverr: 1'b0,
    prdata:  32'h0000_0000
  };

  bpsd_regs_type            s_q;
  bpsd_regs_type            s_d;
  bpsd_pkg::bpsd_apb_req_type req;
  bpsd_pkg::bpsd_lamps_type lamps_nxt;
  bpsd_pkg::bpsd_lamps_type lamps_view;
  logic                     apb_wr;
  logic                     res_wr;
  logic                     res_ok;
  logic                     restart_wr;

  assign req        = '{PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I};
  assign apb_wr     = req.sel && req.enable && s_q.pready && req.write;
  assign res_wr     = apb_wr && (req.addr == bpsd_pkg::RESULT_OFS);
  assign res_ok     = req.wdata[bpsd_pkg::RES_OK_BIT];
  assign restart_wr = apb_wr && (req.addr == bpsd_pkg::CTRL_OFS)
                      && req.wdata[bpsd_pkg::CTRL_RESTART_BIT];

  // ----------------------------------------------------------------
  // sequence decoding
  // ----------------------------------------------------------------
  function automatic logic [4:0] next_code(input logic [4:0] c, input logic ok);
    logic [4:0] n;
    n = c + 5'h01;
    case (c)
      bpsd_pkg::C_RESET:       n = bpsd_pkg::C_PAGE_ADDR;
      bpsd_pkg::C_TAPE_INIT:   n = ok ? bpsd_pkg::C_TAPE_DUMP
                                      : bpsd_pkg::C_NVM_RELOAD;
      bpsd_pkg::C_NVM_RELOAD:  n = ok ? bpsd_pkg::C_DUMP_SRCH
                                      : bpsd_pkg::C_RECAL;
      bpsd_pkg::C_RECAL:       n = ok ? bpsd_pkg::C_DUMP_SRCH
                                      : bpsd_pkg::C_RECAL;
      bpsd_pkg::C_TAPE_DUMP:   n = bpsd_pkg::C_BASE_ADDR;
      bpsd_pkg::C_DUMP_SRCH:   n = ok ? bpsd_pkg::C_DISK_DUMP
                                      : bpsd_pkg::C_BASE_ADDR;
      bpsd_pkg::C_DISK_DUMP:   n = bpsd_pkg::C_BASE_ADDR;
      bpsd_pkg::C_LOADER_SRCH: n = ok ? bpsd_pkg::C_LOAD_LDR
                                      : bpsd_pkg::C_NVM_RELOAD2;
      bpsd_pkg::C_NVM_RELOAD2: n = ok ? bpsd_pkg::C_DISK_SRCH
                                      : bpsd_pkg::C_RECAL2;
      bpsd_pkg::C_RECAL2:      n = ok ? bpsd_pkg::C_DISK_SRCH
                                      : bpsd_pkg::C_RECAL2;
      bpsd_pkg::C_DISK_SRCH:   n = ok ? bpsd_pkg::C_LOAD_LDR
                                      : bpsd_pkg::C_DISK_SRCH;
      default:                 n = c + 5'h01;
    endcase
    return n;
  endfunction

  // steps whose failure is a branch rather than a halt
  function automatic logic fail_branches(input logic [4:0] c);
    case (c)
      bpsd_pkg::C_TAPE_INIT, bpsd_pkg::C_NVM_RELOAD, bpsd_pkg::C_RECAL,
      bpsd_pkg::C_DUMP_SRCH, bpsd_pkg::C_LOADER_SRCH, bpsd_pkg::C_NVM_RELOAD2,
      bpsd_pkg::C_RECAL2, bpsd_pkg::C_DISK_SRCH: fail_branches = 1'b1;
      default:                                   fail_branches = 1'b0;
    endcase
  endfunction

  // page and base memory tests (up to 13h) map to fixed error codes, others take the firmware's
  function automatic logic [4:0] error_code(input logic [4:0] c, input logic [4:0] sw);
    logic [4:0] e;
    e = sw;
    case (c)
      bpsd_pkg::C_PAGE_ADDR: e = bpsd_pkg::E_PAGE_ADDR;
      bpsd_pkg::C_PAGE_INV:  e = bpsd_pkg::E_PAGE_INV;
      bpsd_pkg::C_PAGE_ZERO: e = bpsd_pkg::E_PAGE_ZERO;
      bpsd_pkg::C_PAGE_ONE:  e = bpsd_pkg::E_PAGE_ONE;
      default: begin
        if (c >= bpsd_pkg::C_BASE_ADDR && c <= bpsd_pkg::C_BASE_LAST) begin
          e = c;
        end
      end
    endcase
    return e;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d         = s_q;
    s_d.go      = 1'b0;
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0000_0000;

    // answer one cycle after setup, so pready is a flop
    if (req.sel && !req.enable) begin
      s_d.pready = 1'b1;
      case (req.addr)
        bpsd_pkg::CTRL_OFS:   s_d.prdata[2:0] = s_q.ctrl;
        bpsd_pkg::RESULT_OFS: s_d.prdata = 32'h0000_0000;
        bpsd_pkg::STATUS_OFS: begin
          s_d.prdata[4:0] = s_q.code;
          s_d.prdata[bpsd_pkg::STAT_ERR_BIT] = s_q.err;
          s_d.prdata[bpsd_pkg::STAT_STATE_LSB +: 2] = s_q.state;
          s_d.prdata[bpsd_pkg::STAT_PEND_BIT] = (s_q.state == bpsd_pkg::ST_WAIT);
        end
        bpsd_pkg::LAMPS_OFS:  s_d.prdata[7:0] = lamps_view;
        default:              s_d.pslverr = 1'b1;
      endcase
    end

    if (apb_wr && req.addr == bpsd_pkg::CTRL_OFS) begin
      s_d.ctrl = req.wdata[2:0];
    end

    case (s_q.state)
      bpsd_pkg::ST_ENTER: begin
        s_d.go    = 1'b1;
        s_d.state = bpsd_pkg::ST_WAIT;
      end
      bpsd_pkg::ST_WAIT: begin
        if (res_wr) begin
          if (res_ok || fail_branches(s_q.code)) begin
            if (s_q.code == bpsd_pkg::C_EXEC_LDR) begin
              s_d.state = bpsd_pkg::ST_DONE;
            end else begin
              s_d.code  = next_code(s_q.code, res_ok);
              s_d.state = bpsd_pkg::ST_ENTER;
            end
          end else begin
            s_d.err   = 1'b1;
            s_d.code  = error_code(s_q.code, req.wdata[bpsd_pkg::RES_ERR_LSB +: 5]);
            s_d.state = bpsd_pkg::ST_HALT;
          end
        end
      end
      bpsd_pkg::ST_HALT: s_d.state = bpsd_pkg::ST_HALT;
      bpsd_pkg::ST_DONE: s_d.state = bpsd_pkg::ST_DONE;
      default:           s_d.state = bpsd_pkg::ST_ENTER;
    endcase

    // software restart behaves like a reset of the sequence
    if (restart_wr) begin
      s_d.state = bpsd_pkg::ST_ENTER;
      s_d.code  = bpsd_pkg::C_RESET;
      s_d.err   = 1'b0;
      s_d.go    = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      s_q <= S_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // lamp picture
  // ----------------------------------------------------------------
  always_comb begin
    lamps_nxt.err  = s_q.err;
    lamps_nxt.code = s_q.code;
    if (s_q.ctrl[bpsd_pkg::CTRL_RUN_BIT]) begin
      lamps_nxt.exec   = s_q.ctrl[bpsd_pkg::CTRL_USER_BIT];
      lamps_nxt.loader = s_q.ctrl[bpsd_pkg::CTRL_IDLE_BIT];
    end else begin
      lamps_nxt.exec   = !(s_q.code == bpsd_pkg::C_EXEC_LDR && !s_q.err);
      lamps_nxt.loader = (s_q.code == bpsd_pkg::C_EXEC_LDR && !s_q.err);
    end
  end

  bpsd_lamp_hold u_lamps (
    .clock_i   (CLOCK_I),
    .reset_n_i (RESET_N_I),
    .load_i    (lamps_nxt != lamps_view),
    .lamps_i   (lamps_nxt),
    .lamps_o   (lamps_view)
  );

  assign ERROR_FLAG_LAMP_O   = lamps_view.err;
  assign LOADER_PHASE_LAMP_O = lamps_view.loader;
  assign EXEC_SOURCE_LAMP_O  = lamps_view.exec;
  assign CODE_LAMPS_O        = lamps_view.code;
  assign STEP_GO_O           = s_q.go;
  assign STEP_CODE_O         = s_q.code;
  assign PRDATA_O            = s_q.prdata;
  assign PREADY_O            = s_q.pready;
  assign PSLVERR_O           = s_q.pslverr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESET_N_I);

  unused_code_a: assert property (!s_q.err |-> s_q.code != bpsd_pkg::C_UNUSED)
    else $error("status 01h shown");
  restart_seq_a: assert property (restart_wr |=> s_q.code == bpsd_pkg::C_RESET ##1 STEP_GO_O)
    else $error("restart did not re-enter 00h");
  tape_branch_a: assert property (res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT
    && s_q.code == bpsd_pkg::C_TAPE_INIT && !restart_wr |=> s_q.code == bpsd_pkg::C_TAPE_DUMP)
    else $error("tape init success did not go to 0Dh");
  recal_hold_a: assert property (res_wr && !res_ok && s_q.state == bpsd_pkg::ST_WAIT
    && s_q.code == bpsd_pkg::C_RECAL |=> s_q.code == bpsd_pkg::C_RECAL && !s_q.err)
    else $error("recalibration failure left 0Ch");
  tape_dump_a: assert property (res_wr && s_q.state == bpsd_pkg::ST_WAIT
    && s_q.code == bpsd_pkg::C_TAPE_DUMP |=> s_q.code == bpsd_pkg::C_BASE_ADDR)
    else $error("tape dump did not continue at 10h");
  loader_find_a: assert property (res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT
    && s_q.code == bpsd_pkg::C_LOADER_SRCH |=> s_q.code == bpsd_pkg::C_LOAD_LDR)
    else $error("loader found but not at 1Eh");
  base_fail_a: assert property (res_wr && !res_ok && s_q.state == bpsd_pkg::ST_WAIT
    && s_q.code == bpsd_pkg::C_BASE_ADDR |=> s_q.err && s_q.code == bpsd_pkg::C_BASE_ADDR
    ##1 ERROR_FLAG_LAMP_O && CODE_LAMPS_O == bpsd_pkg::C_BASE_ADDR)
    else $error("base test failure not shown as error 10h");
  err_lamp_a: assert property (ERROR_FLAG_LAMP_O == $past(s_q.err))
    else $error("error lamp out of step with error state");
  code_lamp_a: assert property (CODE_LAMPS_O == $past(s_q.code))
    else $error("code lamps out of step with code");
  exec_rom_a: assert property (!s_q.ctrl[bpsd_pkg::CTRL_RUN_BIT]
    && s_q.code != bpsd_pkg::C_EXEC_LDR |=> EXEC_SOURCE_LAMP_O)
    else $error("source lamp dark while running from rom");
  halt_hold_a: assert property (s_q.state == bpsd_pkg::ST_HALT && !restart_wr
    |=> $stable(s_q.code) && s_q.err)
    else $error("halted code changed");

  // step branches and lamp drive
  go_pulse_a: assert property (
    s_q.state == bpsd_pkg::ST_ENTER && !restart_wr |=> STEP_GO_O)
    else $error("no step request after entering a code");
  reset_entry_a: assert property (
    RESET_N_I && !$past(RESET_N_I) |-> s_q.code == bpsd_pkg::C_RESET && !ERROR_FLAG_LAMP_O)
    else $error("sequence did not start at 00h after reset");
  page_order_a: assert property (
    res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code == bpsd_pkg::C_PAGE_ADDR
    |=> s_q.code == bpsd_pkg::C_PAGE_INV)
    else $error("address pattern test not followed by 03h");
  page_fail_a: assert property (
    res_wr && !res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code == bpsd_pkg::C_PAGE_ADDR
    |=> s_q.err && s_q.code == bpsd_pkg::E_PAGE_ADDR)
    else $error("page address failure not shown as error 14h");
  tape_fail_a: assert property (
    res_wr && !res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code == bpsd_pkg::C_TAPE_INIT
    |=> s_q.code == bpsd_pkg::C_NVM_RELOAD && !s_q.err)
    else $error("tape init failure did not go to 0Bh");
  nvm_branch_a: assert property (
    res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code == bpsd_pkg::C_NVM_RELOAD
    |=> s_q.code == bpsd_pkg::C_DUMP_SRCH)
    else $error("config reload success did not go to 0Eh");
  recal_ok_a: assert property (
    res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code == bpsd_pkg::C_RECAL
    |=> s_q.code == bpsd_pkg::C_DUMP_SRCH)
    else $error("recalibration success did not go to 0Eh");
  dump_fail_a: assert property (
    res_wr && !res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code == bpsd_pkg::C_DUMP_SRCH
    |=> s_q.code == bpsd_pkg::C_BASE_ADDR && !s_q.err)
    else $error("dump area not found but not at 10h");
  disk_dump_a: assert property (
    res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code == bpsd_pkg::C_DISK_DUMP
    |=> s_q.code == bpsd_pkg::C_BASE_ADDR)
    else $error("disk dump did not continue at 10h");
  base_step_a: assert property (
    res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code >= bpsd_pkg::C_BASE_ADDR
    && s_q.code < bpsd_pkg::C_EXP_LAST |=> s_q.code == $past(s_q.code) + 5'h01)
    else $error("memory test did not advance by one code");
  loader_exec_a: assert property (
    res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT && s_q.code == bpsd_pkg::C_LOAD_LDR
    |=> s_q.code == bpsd_pkg::C_EXEC_LDR)
    else $error("loader load did not go to 1Fh");
  loader_lamp_a: assert property (
    !s_q.ctrl[bpsd_pkg::CTRL_RUN_BIT] && s_q.code == bpsd_pkg::C_EXEC_LDR && !s_q.err
    |=> LOADER_PHASE_LAMP_O && !EXEC_SOURCE_LAMP_O)
    else $error("loader lamps wrong while loader runs");
  run_lamps_a: assert property (
    s_q.ctrl[bpsd_pkg::CTRL_RUN_BIT]
    |=> EXEC_SOURCE_LAMP_O == $past(s_q.ctrl[bpsd_pkg::CTRL_USER_BIT])
    && LOADER_PHASE_LAMP_O == $past(s_q.ctrl[bpsd_pkg::CTRL_IDLE_BIT]))
    else $error("run mode lamps do not follow control");
  no_err_ok_a: assert property (
    res_wr && res_ok && s_q.state == bpsd_pkg::ST_WAIT |=> !s_q.err && !ERROR_FLAG_LAMP_O)
    else $error("error shown after a good step");
  code_hold_a: assert property (
    s_q.state == bpsd_pkg::ST_WAIT && !res_wr && !restart_wr
    |=> $stable(s_q.code) && $stable(s_q.err))
    else $error("code moved without a result");
  restart_clear_a: assert property (
    restart_wr |=> !s_q.err && s_q.state == bpsd_pkg::ST_ENTER)
    else $error("restart did not clear the error");

endmodule
`default_nettype wire
